// ### pkg/iffs_pkg.sv
// Constants for the I2C FIFO status and flush block
// How it works
// R1: Writing one to master flush bit empties master transmit FIFO; zero does nothing.
// R2: Software flushes master transmit FIFO after arbitration loss or slave not-acknowledge.
// R3: Writing one to slave flush bit empties slave transmit FIFO; zero does nothing.
// R4: Bits 7:6 read master receive FIFO byte count, never 11.
// R5: Bits 5:4 read master transmit FIFO byte count, never 11.
// R6: Bits 3:2 read slave receive FIFO byte count.
// R7: Bits 1:0 read slave transmit FIFO byte count.
// R8: Writing one to shared bit 0 reinitialises start and stop detectors.
// R9: The same write clears the line-busy indication, reporting the bus idle.
// R10: After a transmit flush its count reads empty until new bytes arrive.
package iffs_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] FIFO_OCC_ADDR = 32'h4000344C;
  localparam logic [ADDR_W-1:0] SHARED_RST_ADDR = 32'h40003450;
  localparam int MTX_FLUSH_BIT = 9;
  localparam int STX_FLUSH_BIT = 8;
  localparam int MRX_LSB = 6;
  localparam int MTX_LSB = 4;
  localparam int SRX_LSB = 2;
  localparam int STX_LSB = 0;
  localparam int DET_RST_BIT = 0;
  localparam int FIFO_DEPTH = 2;
  localparam logic [1:0] CNT_EMPTY = 2'h0;
  localparam logic [DATA_W-1:0] RESET_VALUE = 16'h0000;
endpackage

// ### design/iffs_top.sv
// FIFO occupancy counters, transmit flushes and shared detector reset
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
module iffs_top
(
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic [iffs_pkg::ADDR_W-1:0] addr,
  input  wire logic [iffs_pkg::DATA_W-1:0] wdata,
  input  wire logic                        wr_stb,
  input  wire logic                        rd_stb,
  output logic      [iffs_pkg::DATA_W-1:0] rdata,
  input  wire logic                        mrx_push,
  input  wire logic                        mrx_pop,
  input  wire logic                        mtx_push,
  input  wire logic                        mtx_pop,
  input  wire logic                        srx_push,
  input  wire logic                        srx_pop,
  input  wire logic                        stx_push,
  input  wire logic                        stx_pop,
  input  wire logic                        start_seen,
  input  wire logic                        stop_seen,
  output logic                             master_tx_flush,
  output logic                             slave_tx_flush,
  output logic                             detector_reset,
  output logic                             bus_line_occupied,
  output logic      [1:0]                  master_rx_count,
  output logic      [1:0]                  master_tx_count,
  output logic      [1:0]                  slave_rx_count,
  output logic      [1:0]                  slave_tx_count
);
  import iffs_pkg::*;

  typedef struct packed {
    logic [1:0]        cnt_mrx;
    logic [1:0]        cnt_mtx;
    logic [1:0]        cnt_srx;
    logic [1:0]        cnt_stx;
    logic              busy;
    logic              mtx_flush;
    logic              stx_flush;
    logic              detrst;
    logic [DATA_W-1:0] rdata;
  } iffs_state_type;

  iffs_state_type st_reg;
  iffs_state_type st_next;

  logic wr_fifo;
  logic wr_shared;
  logic do_mtx_flush;
  logic do_stx_flush;
  logic do_detrst;

  // Full byte addresses are decoded, so any other address is ignored
  assign wr_fifo = wr_stb && (addr == FIFO_OCC_ADDR);
  assign wr_shared = wr_stb && (addr == SHARED_RST_ADDR);
  assign do_mtx_flush = wr_fifo && wdata[MTX_FLUSH_BIT]; // [R1]
  assign do_stx_flush = wr_fifo && wdata[STX_FLUSH_BIT]; // [R3]
  assign do_detrst = wr_shared && wdata[DET_RST_BIT];    // [R8]

  // Saturating occupancy count; push and pop together leave it unchanged, except that an empty count goes to one
  function automatic logic [1:0] step(input logic [1:0] c, input logic push,
                                      input logic pop);
    logic [1:0] n;
    n = c;
    if (push && !pop && c < 2'(FIFO_DEPTH))
      n = c + 2'h1;
    else if (pop && !push && c != CNT_EMPTY)
      n = c - 2'h1;
    else if (pop && push && c == CNT_EMPTY)
      n = 2'h1;
    return n;
  endfunction

  always_comb
  begin
    st_next = st_reg;
    st_next.cnt_mrx = step(st_reg.cnt_mrx, mrx_push, mrx_pop); // [R4]
    st_next.cnt_srx = step(st_reg.cnt_srx, srx_push, srx_pop); // [R6]
    // A flush drops the pushes of the same cycle too
    st_next.cnt_mtx = do_mtx_flush ? CNT_EMPTY
                    : step(st_reg.cnt_mtx, mtx_push, mtx_pop); // [R5] [R10]
    st_next.cnt_stx = do_stx_flush ? CNT_EMPTY
                    : step(st_reg.cnt_stx, stx_push, stx_pop); // [R7] [R10]
    // Detector reset wins over a start seen in the same cycle
    if (do_detrst)
      st_next.busy = 1'b0; // [R9]
    else if (start_seen)
      st_next.busy = 1'b1;
    else if (stop_seen)
      st_next.busy = 1'b0;
    st_next.mtx_flush = do_mtx_flush;
    st_next.stx_flush = do_stx_flush;
    st_next.detrst = do_detrst;
    st_next.rdata = RESET_VALUE;
    // Flush and detector reset bits are write-only and read zero
    if (rd_stb && addr == FIFO_OCC_ADDR)
    begin
      st_next.rdata[MRX_LSB +: 2] = st_reg.cnt_mrx;
      st_next.rdata[MTX_LSB +: 2] = st_reg.cnt_mtx;
      st_next.rdata[SRX_LSB +: 2] = st_reg.cnt_srx;
      st_next.rdata[STX_LSB +: 2] = st_reg.cnt_stx;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Every output comes straight from a flip-flop, so the engines see no glitches
  assign rdata = st_reg.rdata;
  assign master_tx_flush = st_reg.mtx_flush;
  assign slave_tx_flush = st_reg.stx_flush;
  assign detector_reset = st_reg.detrst;
  assign bus_line_occupied = st_reg.busy;
  assign master_rx_count = st_reg.cnt_mrx;
  assign master_tx_count = st_reg.cnt_mtx;
  assign slave_rx_count = st_reg.cnt_srx;
  assign slave_tx_count = st_reg.cnt_stx;

  // Flush controls: one pulse after a write of one, count empty afterwards
  mtx_flush_empty_a: assert property (@(posedge mclk) disable iff (rst) // [R1]
    do_mtx_flush |=> master_tx_count == CNT_EMPTY && master_tx_flush)
    else $error("master flush did not empty count");
  stx_flush_empty_a: assert property (@(posedge mclk) disable iff (rst) // [R3]
    do_stx_flush |=> slave_tx_count == CNT_EMPTY && slave_tx_flush)
    else $error("slave flush did not empty count");
  zero_noflush_a: assert property (@(posedge mclk) disable iff (rst) // [R1]
    wr_fifo && !wdata[MTX_FLUSH_BIT] && !mtx_pop && mtx_push
      |=> master_tx_count != CNT_EMPTY)
    else $error("zero write flushed master fifo");
  slave_noflush_a: assert property (@(posedge mclk) disable iff (rst) // [R3]
    wr_fifo && !wdata[STX_FLUSH_BIT] && !stx_pop && stx_push
      |=> slave_tx_count != CNT_EMPTY)
    else $error("zero write flushed slave fifo");
  mtx_pulse_only_a: assert property (@(posedge mclk) disable iff (rst) // [R1]
    !do_mtx_flush |=> !master_tx_flush)
    else $error("master flush pulse without write");
  stx_pulse_only_a: assert property (@(posedge mclk) disable iff (rst) // [R3]
    !do_stx_flush |=> !slave_tx_flush)
    else $error("slave flush pulse without write");
  unmapped_write_a: assert property (@(posedge mclk) disable iff (rst) // [R1]
    wr_stb && addr != FIFO_OCC_ADDR |=> !master_tx_flush && !slave_tx_flush)
    else $error("flush from another address");
  flush_hold_a: assert property (@(posedge mclk) disable iff (rst) // [R10]
    master_tx_flush && !mtx_push |=> master_tx_count == CNT_EMPTY)
    else $error("flushed count changed without push");
  stx_flush_hold_a: assert property (@(posedge mclk) disable iff (rst) // [R10]
    slave_tx_flush && !stx_push |=> slave_tx_count == CNT_EMPTY)
    else $error("flushed slave count changed without push");

  // Occupancy counts: never the reserved code, one step at a time, saturate when full
  mrx_range_a: assert property (@(posedge mclk) disable iff (rst) // [R4]
    master_rx_count != 2'h3)
    else $error("master rx count reads 11");
  mtx_range_a: assert property (@(posedge mclk) disable iff (rst) // [R5]
    master_tx_count != 2'h3)
    else $error("master tx count reads 11");
  srx_range_a: assert property (@(posedge mclk) disable iff (rst) // [R6]
    slave_rx_count != 2'h3)
    else $error("slave rx count reads 11");
  stx_range_a: assert property (@(posedge mclk) disable iff (rst) // [R7]
    slave_tx_count != 2'h3)
    else $error("slave tx count reads 11");
  mrx_pop_a: assert property (@(posedge mclk) disable iff (rst) // [R4]
    mrx_pop && !mrx_push && master_rx_count != CNT_EMPTY
      |=> master_rx_count == $past(master_rx_count) - 2'h1)
    else $error("master rx pop did not count down");
  mtx_push_a: assert property (@(posedge mclk) disable iff (rst) // [R5]
    !do_mtx_flush && mtx_push && !mtx_pop && master_tx_count < 2'(FIFO_DEPTH)
      |=> master_tx_count == $past(master_tx_count) + 2'h1)
    else $error("master tx push did not count up");
  mtx_full_a: assert property (@(posedge mclk) disable iff (rst) // [R5]
    !do_mtx_flush && mtx_push && !mtx_pop && master_tx_count == 2'(FIFO_DEPTH)
      |=> master_tx_count == 2'(FIFO_DEPTH))
    else $error("master tx count left full on push");
  srx_push_a: assert property (@(posedge mclk) disable iff (rst) // [R6]
    srx_push && !srx_pop && slave_rx_count < 2'(FIFO_DEPTH)
      |=> slave_rx_count == $past(slave_rx_count) + 2'h1)
    else $error("slave rx push did not count up");
  stx_pop_a: assert property (@(posedge mclk) disable iff (rst) // [R7]
    !do_stx_flush && stx_pop && !stx_push && slave_tx_count != CNT_EMPTY
      |=> slave_tx_count == $past(slave_tx_count) - 2'h1)
    else $error("slave tx pop did not count down");

  // Read port: fields as of the read cycle, zero in every other cycle
  mrx_read_a: assert property (@(posedge mclk) disable iff (rst) // [R4]
    rd_stb && addr == FIFO_OCC_ADDR |=> rdata[MRX_LSB +: 2] == $past(master_rx_count))
    else $error("master rx field mismatch");
  mtx_read_a: assert property (@(posedge mclk) disable iff (rst) // [R5]
    rd_stb && addr == FIFO_OCC_ADDR |=> rdata[MTX_LSB +: 2] == $past(master_tx_count))
    else $error("master tx field mismatch");
  srx_read_a: assert property (@(posedge mclk) disable iff (rst) // [R6]
    rd_stb && addr == FIFO_OCC_ADDR |=> rdata[SRX_LSB +: 2] == $past(slave_rx_count))
    else $error("slave rx field mismatch");
  stx_read_a: assert property (@(posedge mclk) disable iff (rst) // [R7]
    rd_stb && addr == FIFO_OCC_ADDR |=> rdata[STX_LSB +: 2] == $past(slave_tx_count))
    else $error("slave tx field mismatch");
  rd_idle_zero_a: assert property (@(posedge mclk) disable iff (rst) // [R4]
    !(rd_stb && addr == FIFO_OCC_ADDR) |=> rdata == RESET_VALUE)
    else $error("read data not zero outside a read");
  flush_reads_zero_a: assert property (@(posedge mclk) disable iff (rst) // [R1]
    rd_stb |=> rdata[DATA_W-1:STX_FLUSH_BIT] == '0)
    else $error("write-only bits read back");

  // Shared reset: one pulse per write of one, and the line reads idle afterwards
  det_pulse_a: assert property (@(posedge mclk) disable iff (rst) // [R8]
    do_detrst |=> detector_reset ##1 !detector_reset || $past(do_detrst))
    else $error("detector reset pulse wrong");
  det_only_write_a: assert property (@(posedge mclk) disable iff (rst) // [R8]
    !do_detrst |=> !detector_reset)
    else $error("detector reset pulse without write");
  busy_clear_a: assert property (@(posedge mclk) disable iff (rst) // [R9]
    do_detrst |=> !bus_line_occupied)
    else $error("line busy not cleared");
  busy_set_a: assert property (@(posedge mclk) disable iff (rst) // [R9]
    start_seen && !do_detrst |=> bus_line_occupied)
    else $error("line busy not set by start");
  busy_stop_a: assert property (@(posedge mclk) disable iff (rst) // [R9]
    stop_seen && !start_seen && !do_detrst |=> !bus_line_occupied)
    else $error("line busy not cleared by stop");
endmodule

// ### verif/iffs_eng_model.sv
// Serial engine and detector stand-in giving event pulses
`timescale 1ns/100ps
module iffs_eng_model
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [9:0] req,
  output logic      [9:0] ev
);
  // Registered so events land a cycle after the bench draws them, like a real engine
  always_ff @(posedge mclk)
  begin
    ev <= rst ? 10'h000 : req;
  end
endmodule

// ### verif/iffs_tb_top.sv
// Random self-checking bench for FIFO status, flush and detector reset
`timescale 1ns/100ps
module iffs_tb_top;
  import iffs_pkg::*;
  logic        mclk, rst, wr_stb, rd_stb, mf, sf, dr, busy;
  logic [31:0] addr;
  logic [15:0] wdata, rdata, exp_rd, exp_cnt;
  logic [9:0]  req, ev;
  logic [1:0]  mrc, mtc, src, stc;
  logic [2:0]  exp_p;
  int          c[4], busy_m, err_total, checked, run, op;
  iffs_eng_model i_eng (.mclk(mclk), .rst(rst), .req(req), .ev(ev));
  iffs_top i_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .mrx_push(ev[0]), .mrx_pop(ev[1]), .mtx_push(ev[2]),
    .mtx_pop(ev[3]), .srx_push(ev[4]), .srx_pop(ev[5]), .stx_push(ev[6]), .stx_pop(ev[7]),
    .start_seen(ev[8]), .stop_seen(ev[9]), .master_tx_flush(mf), .slave_tx_flush(sf),
    .detector_reset(dr), .bus_line_occupied(busy), .master_rx_count(mrc),
    .master_tx_count(mtc), .slave_rx_count(src), .slave_tx_count(stc));
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Model steps on the falling edge: outputs have settled, inputs are not yet taken
  always @(negedge mclk)
  begin
    if (run)
    begin
      exp_cnt = 16'({c[0][1:0], c[1][1:0], c[2][1:0], c[3][1:0]});
      check("counts", 16'({mrc, mtc, src, stc}), exp_cnt);
      check("pulses", 16'({mf, sf, dr, busy}), 16'({exp_p, busy_m[0]}));
      check("rdata", rdata, exp_rd);
      exp_rd = (rd_stb && addr == FIFO_OCC_ADDR) ? exp_cnt : 16'h0000;
      exp_p = (wr_stb && addr == FIFO_OCC_ADDR) ?
        {wdata[MTX_FLUSH_BIT], wdata[STX_FLUSH_BIT], 1'b0} : 3'h0;
      if (wr_stb && addr == SHARED_RST_ADDR)
        exp_p[0] = wdata[DET_RST_BIT];
      // Push and pop together: an empty fifo takes the byte, otherwise no change
      for (int i = 0; i < 4; i++)
        if (ev[2*i] && ev[2*i+1])
          c[i] = (c[i] == 0) ? 1 : c[i];
        else
          c[i] = c[i] + int'(ev[2*i] && c[i] < FIFO_DEPTH) - int'(ev[2*i+1] && c[i] > 0);
      if (exp_p[2])
        c[1] = 0;
      if (exp_p[1])
        c[3] = 0;
      busy_m = exp_p[0] ? 0 : ev[8] ? 1 : ev[9] ? 0 : busy_m;
    end
  end
  initial
  begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    #40000;
    err_total++;
    complete_run();
  end
  initial
  begin
    {wr_stb, rd_stb, addr, wdata, req, exp_p, exp_rd} = 0;
    {run, busy_m, err_total, checked} = 0;
    c = '{default: 0};
    rst = 1;
    void'($urandom(32'h8846));
    repeat (2) @(posedge mclk);
    rst <= 0;
    run <= 1;
    repeat (3000)
    begin
      @(posedge mclk);
      op = $urandom % 8;
      req <= 10'($urandom);
      wr_stb <= op == 0;
      rd_stb <= op == 1;
      // Third address is unmapped and must read zero and ignore writes
      addr <= FIFO_OCC_ADDR + 32'($urandom % 3) * 32'h4;
      wdata <= 16'($urandom);
    end
    @(posedge mclk);
    {wr_stb, rd_stb, req} <= 0;
    repeat (3) @(posedge mclk);
    $display("random traffic test done");
    // Master engine queues two bytes, then software flushes as it would after a not-acknowledge
    req <= 10'h004;
    repeat (2) @(posedge mclk);
    req <= 10'h000;
    repeat (2) @(negedge mclk);
    check("queued count", 16'(mtc), 16'h0002);
    @(posedge mclk);
    wr_stb <= 1'b1;
    addr <= FIFO_OCC_ADDR;
    wdata <= 16'h0001 << MTX_FLUSH_BIT;
    @(posedge mclk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(negedge mclk);
    check("flushed count", 16'(mtc), 16'h0000);
    @(posedge mclk);
    rd_stb <= 1'b0;
    repeat (3) @(posedge mclk);
    $display("flush after not-acknowledge test done");
    complete_run();
  end
endmodule
